//--- rtl/bitop_branch_exec.sv
// Execution unit for bit invert, overflow branch and bit-test skips.
// Overview of operation
// - Bit invert flips bit b of the addressed byte and writes it back.
// - Bit invert opcode is 0111, then 3-bit index, access bit, address.
// - Access bit 0 uses the access bank and ignores the bank register.
// - Access bit 1 builds the address from the bank register.
// - Overflow branch loads PC+2+2n only when the overflow flag is 1.
// - Offset is 8-bit two's complement, sign-extended before doubling.
// - Overflow branch is upper byte 1110 0100, offset in low byte.
// - Taken branch costs two cycles with a flush; untaken costs one.
module bitop_branch_exec (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rst,
   // Fetch path: instruction word being executed and the one prefetched.
   input wire logic [15:0] instr_word,
   input wire logic [15:0] next_word,
   // Core state inputs.
   input wire logic ovf_flag,
   input wire logic [3:0] bank_select_reg,
   input wire logic [bitop_pkg::PC_W-1:0] pc_in,
   // Data memory read data.
   input wire logic [7:0] mem_rdata,
   // Data memory access.
   output logic [bitop_pkg::ADDR_W-1:0] mem_addr,
   output logic mem_we,
   output logic [7:0] mem_wdata,
   // Program counter load and phase indication.
   output logic pc_we,
   output logic [bitop_pkg::PC_W-1:0] pc_wdata,
   output logic [1:0] q_phase,
   output logic flush_active
);
   import bitop_pkg::*;

   // Phase counter and flush sequencer state.
   logic [1:0] q_r;
   ex_state_t state_r;
   ex_state_t state_nxt;
   // Operand address, modified byte and branch target held across phases.
   logic [ADDR_W-1:0] addr_comb;
   logic [ADDR_W-1:0] addr_r;
   logic [7:0] data_r;
   logic [PC_W-1:0] target_r;
   // Decode results and fields of the word in execution.
   logic is_invert;
   logic is_bov;
   logic is_skip;
   logic skip_cond;
   logic next_long;
   logic executing;
   logic take_r;
   logic [2:0] bit_idx;
   logic [PC_W-1:0] offset_ext;

   // Opcode decode; only meaningful outside flush cycles.
   assign executing = (state_r == EX_NORMAL);
   assign is_invert = instr_word[15:OP_HI_POS] == OPC_BIT_INVERT;
   assign is_bov = instr_word[15:8] == OPC_BRANCH_OVF;
   assign is_skip = (instr_word[15:OP_HI_POS] == OPC_SKIP_CLEAR) ||
      (instr_word[15:OP_HI_POS] == OPC_SKIP_SET);
   assign bit_idx = instr_word[BIT_POS+2:BIT_POS];
   // Set-skip has low opcode bit 0, clear-skip has it 1.
   assign skip_cond = instr_word[OP_HI_POS] ? ~mem_rdata[bit_idx]
      : mem_rdata[bit_idx];
   // Prefetched word decides whether one or two words are discarded.
   assign next_long = (next_word[15:9] == OPC_CALL_HI) ||
      (next_word[15:8] == OPC_GOTO_LO) || (next_word[15:8] == OPC_LFSR) ||
      (next_word[15:OP_HI_POS] == OPC_MOVFF);
   // Offset sign extension happens before the doubling shift.
   assign offset_ext = {{(PC_W-8){instr_word[7]}}, instr_word[7:0]};

   bank_addr_gen u_addr (
      .file_addr(instr_word[7:0]),
      .access_sel(instr_word[ACC_POS]),
      .bank_select_reg(bank_select_reg),
      .data_addr(addr_comb)
   );

   // Four-phase counter: Q1 decode, Q2 read, Q3 process, Q4 write.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         q_r <= 2'h0;
      end else begin
         q_r <= q_r + 2'h1;
      end
   end

   // Flush sequencing decided at Q4 of each instruction cycle.
   always_comb begin
      state_nxt = state_r;
      if (q_r == Q_LAST) begin
         case (state_r)
            EX_NORMAL: begin
               // The PC load already holds the Q3 overflow decision, so a
               // flag that moves in Q4 cannot split the load from the flush.
               if (pc_we) begin
                  state_nxt = EX_FLUSH1;
               end else if (is_skip && take_r) begin
                  state_nxt = next_long ? EX_FLUSH2 : EX_FLUSH1;
               end
            end
            EX_FLUSH2: state_nxt = EX_FLUSH1;
            EX_FLUSH1: state_nxt = EX_NORMAL;
            default: state_nxt = EX_NORMAL;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_r <= EX_NORMAL;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Operand address latched in Q1 so it holds still for the Q4 write,
   // even if the bank register changes while the instruction runs.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         addr_r <= '0;
      end else if (executing && (q_r == 2'h0)) begin
         addr_r <= addr_comb;
      end
   end

   // Modified byte formed at the end of Q2 from the read data. The mask
   // has a single set bit, so the other seven bits pass unchanged.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         data_r <= BYTE_RESET;
      end else if (executing && (q_r == 2'h1)) begin
         data_r <= mem_rdata ^ (8'h01 << bit_idx);
      end
   end

   // Skip decision taken from the same Q2 read. It is acted upon only
   // for the two test-and-skip opcodes, so a stale value does no harm.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         take_r <= 1'b0;
      end else if (executing && (q_r == 2'h1)) begin
         take_r <= skip_cond;
      end
   end

   // Branch target formed at the end of Q2 so it is ready for the Q3
   // edge that raises the PC load. The fetch has already advanced the
   // PC, hence the extra word step on top of the doubled offset.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         target_r <= PC_RESET;
      end else if (executing && (q_r == 2'h1)) begin
         target_r <= pc_in + PC_STEP + (offset_ext << 1);
      end
   end

   // Memory address presented from Q2 on. In Q1 the freshly formed
   // address goes straight out so the read has a full cycle to settle.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         mem_addr <= '0;
      end else begin
         mem_addr <= (q_r == 2'h0 && executing) ? addr_comb : addr_r;
      end
   end

   // Write strobe for Q4 only. Flush cycles never write, because the
   // decode is ignored while the sequencer is out of its normal state.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         mem_we <= 1'b0;
      end else begin
         mem_we <= executing && is_invert && (q_r == 2'h2);
      end
   end

   // Write data follows the modified byte. It only matters with the
   // strobe, so it runs free and needs no enable of its own.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         mem_wdata <= BYTE_RESET;
      end else begin
         mem_wdata <= data_r;
      end
   end

   // PC load pulses in Q4 of a taken branch only; an untaken branch
   // leaves Q4 idle and the fetch simply carries on.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pc_we <= 1'b0;
      end else begin
         pc_we <= executing && is_bov && ovf_flag && (q_r == 2'h2);
      end
   end

   // Branch target presented alongside the load strobe.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pc_wdata <= PC_RESET;
      end else begin
         pc_wdata <= target_r;
      end
   end

   // Phase reported one cycle behind the internal counter, as the core
   // samples it through its own register stage.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         q_phase <= 2'h0;
      end else begin
         q_phase <= q_r;
      end
   end

   // Flush flag follows the next sequencer state, so it rises in the
   // very first no-operation cycle rather than one cycle late.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         flush_active <= 1'b0;
      end else begin
         flush_active <= (state_nxt != EX_NORMAL);
      end
   end
endmodule

//--- rtl/bitop_pkg.sv
// Package of opcode fields, timing and reset values for the bit/branch unit.
package bitop_pkg;
   localparam int PC_W = 21;
   localparam int ADDR_W = 12;
   // Opcode patterns and field positions.
   localparam logic [3:0] OPC_BIT_INVERT = 4'h7;
   localparam logic [3:0] OPC_SKIP_CLEAR = 4'hb;
   localparam logic [3:0] OPC_SKIP_SET = 4'ha;
   localparam logic [7:0] OPC_BRANCH_OVF = 8'he4;
   localparam int OP_HI_POS = 12;
   localparam int BIT_POS = 9;
   localparam int ACC_POS = 8;
   // Two-word instructions announce themselves by these top-bit prefixes.
   localparam logic [6:0] OPC_CALL_HI = 7'h76;
   localparam logic [3:0] OPC_GOTO_HI = 4'he;
   localparam logic [7:0] OPC_GOTO_LO = 8'hef;
   localparam logic [7:0] OPC_LFSR = 8'hee;
   localparam logic [3:0] OPC_MOVFF = 4'hc;
   // Access bank split: low half maps to bank 0, high half to bank 15.
   localparam logic [7:0] ACC_SPLIT = 8'h80;
   localparam logic [3:0] ACC_HI_BANK = 4'hf;
   // Last quarter-phase index per instruction cycle, and PC step per word.
   localparam logic [1:0] Q_LAST = 2'h3;
   localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
   localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   typedef enum logic [1:0] {
      EX_NORMAL = 2'b00,
      EX_FLUSH1 = 2'b01,
      EX_FLUSH2 = 2'b10
   } ex_state_t;
endpackage

//--- rtl/bank_addr_gen.sv
// Banked data-memory address former for file-addressed instructions.
module bank_addr_gen (
   // Instruction fields.
   input wire logic [7:0] file_addr,
   input wire logic access_sel,
   // Bank register contents.
   input wire logic [3:0] bank_select_reg,
   // Formed data memory address.
   output logic [bitop_pkg::ADDR_W-1:0] data_addr
);
   import bitop_pkg::*;

   // Access bank ignores the bank register; otherwise it selects the page.
   always_comb begin
      if (!access_sel) begin
         if (file_addr < ACC_SPLIT) begin
            data_addr = {4'h0, file_addr};
         end else begin
            data_addr = {ACC_HI_BANK, file_addr};
         end
      end else begin
         data_addr = {bank_select_reg, file_addr};
      end
   end
endmodule

//--- dv/bitop_branch_exec_assertions.sv
// Checker of invert writes, overflow branch loads and flush timing.
module bitop_branch_exec_assertions import bitop_pkg::*; (
   // Clock, reset and inputs.
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [15:0] instr_word,
   input wire logic ovf_flag,
   input wire logic [3:0] bank_select_reg,
   input wire logic [PC_W-1:0] pc_in,
   input wire logic [7:0] mem_rdata,
   // Outputs watched.
   input wire logic [ADDR_W-1:0] mem_addr,
   input wire logic mem_we,
   input wire logic [7:0] mem_wdata,
   input wire logic pc_we,
   input wire logic [PC_W-1:0] pc_wdata,
   input wire logic flush_active
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   logic [PC_W-1:0] tgt;
   logic [ADDR_W-1:0] eaddr;
   // Expected target and address; the offset is doubled after extension.
   assign tgt = pc_in + PC_STEP + {{12{instr_word[7]}}, instr_word[7:0], 1'b0};
   assign eaddr = instr_word[8] ? {bank_select_reg, instr_word[7:0]} :
      {(instr_word[7:0] < ACC_SPLIT) ? 4'h0 : ACC_HI_BANK, instr_word[7:0]};
   sequence flush4;
      flush_active [*4];
   endsequence
   a_we_one_pulse: assert property (mem_we |=> !mem_we)
      else $error("memory write held too long");
   a_wdata_flip: assert property (mem_we |->
      mem_wdata == (mem_rdata ^ (8'h01 << instr_word[11:9])))
      else $error("written byte is not the inverted read");
   a_invert_opcode: assert property (mem_we |->
      instr_word[15:12] == OPC_BIT_INVERT)
      else $error("memory written by another opcode");
   a_bank_addr: assert property (mem_we |-> mem_addr == eaddr)
      else $error("wrong data address");
   a_pc_target: assert property (pc_we |-> pc_wdata == tgt)
      else $error("wrong branch target");
   a_branch_cond: assert property (pc_we |->
      ovf_flag && instr_word[15:8] == OPC_BRANCH_OVF)
      else $error("branch taken without cause");
   a_flush_after: assert property (pc_we |=> flush4)
      else $error("taken branch not flushed");
   a_quiet_flush: assert property (flush_active |-> !mem_we && !pc_we)
      else $error("write during flush");
   a_flush_bound: assert property ($rose(flush_active) |->
      ##[4:8] !flush_active)
      else $error("flush too long");
endmodule
bind bitop_branch_exec bitop_branch_exec_assertions chk_u (.*);

//--- dv/tb_top.sv
// Self-checking bench for the bit invert and overflow branch unit.
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import bitop_pkg::*;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [15:0] instr_word = 16'h0000;
   logic [15:0] next_word = 16'h0000;
   logic ovf_flag = 1'b0;
   logic [3:0] bank_select_reg = 4'h0;
   logic [PC_W-1:0] pc_in = 21'h000000;
   logic [7:0] mem_rdata, mem_wdata;
   logic [ADDR_W-1:0] mem_addr;
   logic mem_we, pc_we, flush_active;
   logic [PC_W-1:0] pc_wdata, pc_seen;
   logic [1:0] q_phase, ph_seen;
   logic [7:0] mem [0:4095];
   int error_cnt = 0;
   int checked = 0;
   int pc_cnt, fl_cnt, we_cnt;
   always #20 sys_clk = ~sys_clk;
   // Memory model; reads are combinational as the fetch timing expects.
   assign mem_rdata = mem[mem_addr];
   always @(posedge sys_clk) begin
      if (mem_we === 1'b1) mem[mem_addr] <= mem_wdata;
      we_cnt += (mem_we === 1'b1);
      fl_cnt += (flush_active === 1'b1);
      pc_cnt += (pc_we === 1'b1);
      if (pc_we === 1'b1) pc_seen = pc_wdata;
      if (mem_we === 1'b1) ph_seen = q_phase;
   end
   bitop_branch_exec dut_u (.sys_clk(sys_clk), .rst(rst),
      .instr_word(instr_word), .next_word(next_word), .ovf_flag(ovf_flag),
      .bank_select_reg(bank_select_reg), .pc_in(pc_in),
      .mem_rdata(mem_rdata), .mem_addr(mem_addr), .mem_we(mem_we),
      .mem_wdata(mem_wdata), .pc_we(pc_we), .pc_wdata(pc_wdata),
      .q_phase(q_phase), .flush_active(flush_active));
   task automatic chk(input string what, input logic [20:0] exp,
      input logic [20:0] got);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One word, then sixteen cycles in all so the phase stays aligned.
   task automatic exec(input logic [15:0] w, input logic [15:0] nw);
      pc_cnt = 0;
      fl_cnt = 0;
      we_cnt = 0;
      instr_word <= w;
      next_word <= nw;
      repeat (4) @(posedge sys_clk);
      instr_word <= 16'h0000;
      repeat (12) @(posedge sys_clk);
   endtask
   task automatic t_invert(input logic a, input logic [7:0] f,
      input logic [2:0] b, input logic [3:0] bk);
      logic [11:0] ea;
      ea = a ? {bk, f} : {(f < ACC_SPLIT) ? 4'h0 : ACC_HI_BANK, f};
      mem[ea] = 8'h5a;
      bank_select_reg <= bk;
      exec({OPC_BIT_INVERT, b, a, f}, 16'h0000);
      chk("invert byte", 8'h5a ^ (8'h01 << b), mem[ea]);
      chk("invert writes", 1, we_cnt);
      // Phase output trails the internal count, so the Q4 write shows 2.
      chk("write phase", 2'h2, ph_seen);
   endtask
   task automatic t_branch(input logic [7:0] op, input logic ov,
      input logic [7:0] n, input logic tk);
      ovf_flag <= ov;
      pc_in <= 21'h001000;
      exec({op, n}, 16'h0000);
      chk("branch loads", tk, pc_cnt);
      if (tk) chk("target", 21'h001002 + {{12{n[7]}}, n, 1'b0},
         pc_seen);
      chk("branch flush", tk ? 4 : 0, fl_cnt);
   endtask
   task automatic t_skip(input logic [3:0] op, input logic [7:0] v,
      input logic [15:0] nw, input logic [3:0] fl);
      mem[12'h020] = v;
      exec({op, 3'h3, 1'b0, 8'h20}, nw);
      chk("skip flush", fl, fl_cnt);
   endtask
   task automatic end_of_test;
      $display("Checks %0d, errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // Reset, then each scenario in turn.
   initial begin
      repeat (2) @(posedge sys_clk);
      chk("reset outputs", 0, {mem_we, pc_we, flush_active});
      rst <= 1'b0;
      t_invert(1'b0, 8'h12, 3'h7, 4'h5);
      t_invert(1'b0, 8'hf3, 3'h0, 4'h5);
      t_invert(1'b1, 8'h34, 3'h4, 4'h9);
      t_branch(OPC_BRANCH_OVF, 1'b1, 8'h80, 1'b1);
      t_branch(OPC_BRANCH_OVF, 1'b1, 8'h7f, 1'b1);
      t_branch(OPC_BRANCH_OVF, 1'b0, 8'h10, 1'b0);
      t_branch(8'he0, 1'b1, 8'h10, 1'b0);
      t_skip(OPC_SKIP_CLEAR, 8'h00, 16'h0000, 4'h4);
      t_skip(OPC_SKIP_CLEAR, 8'h00, 16'hc123, 4'h8);
      t_skip(OPC_SKIP_CLEAR, 8'h08, 16'hc123, 4'h0);
      t_skip(OPC_SKIP_SET, 8'h08, 16'hef00, 4'h8);
      t_skip(OPC_SKIP_SET, 8'h08, 16'hec00, 4'h8);
      t_skip(OPC_SKIP_SET, 8'h08, 16'hee00, 4'h8);
      t_skip(OPC_SKIP_SET, 8'h00, 16'h0000, 4'h0);
      end_of_test();
   end
endmodule
